//--- rtl/sensor_irq_pkg.sv
package sensor_irq_pkg;
	localparam int AMBIENT_W = 16;
	localparam int PROX_W = 8;
	localparam int FLAG_W = 8;
	// Flag register bit positions
	localparam int FLAG_PROT_LEAVE = 7;
	localparam int FLAG_PROT_ENTER = 6;
	localparam int FLAG_AMB_LOW = 5;
	localparam int FLAG_AMB_HIGH = 4;
	localparam int FLAG_PROX_CLOSE = 1;
	localparam int FLAG_PROX_AWAY = 0;
	localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
	localparam logic [FLAG_W-1:0] FLAG_USED_MASK = 8'hF3;
	// Persistence counter width and selector encodings
	localparam int PERS_W = 4;
	localparam int PERS_SEL_W = 2;
	localparam logic [PERS_W-1:0] AMB_PERS_1 = 4'h1;
	localparam logic [PERS_W-1:0] AMB_PERS_2 = 4'h2;
	localparam logic [PERS_W-1:0] AMB_PERS_4 = 4'h4;
	localparam logic [PERS_W-1:0] AMB_PERS_8 = 4'h8;
	localparam logic [PERS_W-1:0] PROX_PERS_1 = 4'h1;
	localparam logic [PERS_W-1:0] PROX_PERS_2 = 4'h2;
	localparam logic [PERS_W-1:0] PROX_PERS_3 = 4'h3;
	localparam logic [PERS_W-1:0] PROX_PERS_4 = 4'h4;
endpackage

//--- rtl/sensor_threshold_interrupt.sv
`timescale 1ns/1ps
// Functional notes
// - With ambient or proximity interrupt enabled, enabled condition drives pin low.
// - Register access never blocked while interrupt pin is asserted.
// - Ambient event when result above high or below low threshold.
// - Proximity event when result above high or below low threshold.
// - All ambient and proximity statuses live in one flag register.
// - Any flag bit going zero to one pulls interrupt pin low.
// - Host read of flag register clears the flags that were set.
// - After flags cleared by read, interrupt pin is released high.
// - Proximity between thresholds raises no proximity interrupt (hysteresis).
// - Flag bits: 7 leave, 6 enter, 5 amb low, 4 amb high, 1 close, 0 away.
// - Ambient event needs 1, 2, 4 or 8 consecutive out-of-window periods.
// - Proximity event needs 1, 2, 3 or 4 consecutive exceeding periods.
module sensor_threshold_interrupt
	import sensor_irq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ambient_irq_enable,
	input wire logic proximity_irq_select,
	input wire logic [PERS_SEL_W-1:0] ambient_persistence,
	input wire logic [PERS_SEL_W-1:0] proximity_persistence,
	input wire logic [AMBIENT_W-1:0] ambient_high_threshold,
	input wire logic [AMBIENT_W-1:0] ambient_low_threshold,
	input wire logic [PROX_W-1:0] proximity_high_threshold,
	input wire logic [PROX_W-1:0] proximity_low_threshold,
	input wire logic ambient_light_valid,
	input wire logic [AMBIENT_W-1:0] ambient_light_data,
	input wire logic proximity_valid,
	input wire logic [PROX_W-1:0] proximity_data,
	input wire logic protection_enter_event,
	input wire logic protection_leave_event,
	input wire logic flag_read,
	output logic [FLAG_W-1:0] flag_rdata,
	output logic irq_pin_out,
	output logic irq_pin_oe
);

	function automatic logic [PERS_W-1:0] amb_pers_count(input logic [PERS_SEL_W-1:0] sel);
		case (sel)
			2'h0: amb_pers_count = AMB_PERS_1;
			2'h1: amb_pers_count = AMB_PERS_2;
			2'h2: amb_pers_count = AMB_PERS_4;
			default: amb_pers_count = AMB_PERS_8;
		endcase
	endfunction

	function automatic logic [PERS_W-1:0] prox_pers_count(input logic [PERS_SEL_W-1:0] sel);
		case (sel)
			2'h0: prox_pers_count = PROX_PERS_1;
			2'h1: prox_pers_count = PROX_PERS_2;
			2'h2: prox_pers_count = PROX_PERS_3;
			default: prox_pers_count = PROX_PERS_4;
		endcase
	endfunction

	// Bits owned by each enable; the protection pair rides on the proximity enable
	function automatic logic [FLAG_W-1:0] enable_mask(input logic amb_en, input logic prox_en);
		enable_mask = '0;
		enable_mask[FLAG_AMB_HIGH] = amb_en;
		enable_mask[FLAG_AMB_LOW] = amb_en;
		enable_mask[FLAG_PROX_CLOSE] = prox_en;
		enable_mask[FLAG_PROX_AWAY] = prox_en;
		enable_mask[FLAG_PROT_ENTER] = prox_en;
		enable_mask[FLAG_PROT_LEAVE] = prox_en;
	endfunction

	// One shot per excursion: later samples find the count already at the need
	function automatic logic reaches_need
	(
		input logic [PERS_W-1:0] cnt,
		input logic [PERS_W-1:0] need
	);
		reaches_need = (cnt + 4'h1) == need;
	endfunction

	logic [PERS_W-1:0] amb_hi_cnt_r;
	logic [PERS_W-1:0] amb_lo_cnt_r;
	logic [PERS_W-1:0] prox_hi_cnt_r;
	logic [PERS_W-1:0] prox_lo_cnt_r;
	logic [FLAG_W-1:0] flags_r;
	logic [FLAG_W-1:0] flags_nxt;
	logic [FLAG_W-1:0] set_nxt;
	logic [PERS_W-1:0] amb_need;
	logic [PERS_W-1:0] prox_need;
	logic amb_above;
	logic amb_below;
	logic prox_above;
	logic prox_below;
	logic amb_hi_fire;
	logic amb_lo_fire;
	logic prox_close_fire;
	logic prox_away_fire;
	logic irq_active;

	assign amb_need = amb_pers_count(ambient_persistence);
	assign prox_need = prox_pers_count(proximity_persistence);
	assign amb_above = ambient_light_data > ambient_high_threshold;
	assign amb_below = ambient_light_data < ambient_low_threshold;
	assign prox_above = proximity_data > proximity_high_threshold;
	// In-window results reset both counts, so no event fires there
	assign prox_below = proximity_data < proximity_low_threshold;

	// Event fires on the sample that makes the count reach the need
	assign amb_hi_fire = ambient_light_valid && amb_above
		&& reaches_need(amb_hi_cnt_r, amb_need);
	assign amb_lo_fire = ambient_light_valid && amb_below
		&& reaches_need(amb_lo_cnt_r, amb_need);
	assign prox_close_fire = proximity_valid && prox_above
		&& reaches_need(prox_hi_cnt_r, prox_need);
	assign prox_away_fire = proximity_valid && prox_below
		&& reaches_need(prox_lo_cnt_r, prox_need);

	// Counts stop at the need, so a lowered need cannot let them wrap and refire
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			amb_hi_cnt_r <= '0;
		else if (ambient_light_valid)
		begin
			if (!amb_above)
				amb_hi_cnt_r <= '0;
			else if (amb_hi_cnt_r < amb_need)
				amb_hi_cnt_r <= amb_hi_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			amb_lo_cnt_r <= '0;
		else if (ambient_light_valid)
		begin
			if (!amb_below)
				amb_lo_cnt_r <= '0;
			else if (amb_lo_cnt_r < amb_need)
				amb_lo_cnt_r <= amb_lo_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			prox_hi_cnt_r <= '0;
		else if (proximity_valid)
		begin
			if (!prox_above)
				prox_hi_cnt_r <= '0;
			else if (prox_hi_cnt_r < prox_need)
				prox_hi_cnt_r <= prox_hi_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			prox_lo_cnt_r <= '0;
		else if (proximity_valid)
		begin
			if (!prox_below)
				prox_lo_cnt_r <= '0;
			else if (prox_lo_cnt_r < prox_need)
				prox_lo_cnt_r <= prox_lo_cnt_r + 4'h1;
		end
	end

	// Enables gate the recording only; counting goes on regardless
	always_comb
	begin
		set_nxt = '0;
		set_nxt[FLAG_AMB_HIGH] = amb_hi_fire;
		set_nxt[FLAG_AMB_LOW] = amb_lo_fire;
		set_nxt[FLAG_PROX_CLOSE] = prox_close_fire;
		set_nxt[FLAG_PROX_AWAY] = prox_away_fire;
		set_nxt[FLAG_PROT_ENTER] = protection_enter_event;
		set_nxt[FLAG_PROT_LEAVE] = protection_leave_event;
		set_nxt = set_nxt & enable_mask(ambient_irq_enable, proximity_irq_select);
	end

	// A set in the read cycle survives: the host sees it on the next read
	always_comb
	begin
		if (flag_read)
			flags_nxt = set_nxt & FLAG_USED_MASK;
		else
			flags_nxt = (flags_r | set_nxt) & FLAG_USED_MASK;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			flags_r <= FLAG_RESET;
		else
			flags_r <= flags_nxt;
	end

	// Read data is registered; the read never stalls, whatever the pin state
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			flag_rdata <= FLAG_RESET;
		else if (flag_read)
			flag_rdata <= flags_r;
	end

	assign irq_active = |flags_nxt;

	// Open drain: output value is always 0, enable pulls the line low
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			irq_pin_out <= 1'b0;
		else
			irq_pin_out <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			irq_pin_oe <= 1'b0;
		else
			irq_pin_oe <= irq_active;
	end

endmodule

//--- bench/irq_chk.sv
`timescale 1ns/1ps
module irq_chk
	import sensor_irq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic proximity_irq_select,
	input wire logic [PERS_SEL_W-1:0] proximity_persistence,
	input wire logic [PROX_W-1:0] proximity_high_threshold,
	input wire logic [PROX_W-1:0] proximity_data,
	input wire logic proximity_valid,
	input wire logic ambient_light_valid,
	input wire logic protection_enter_event,
	input wire logic protection_leave_event,
	input wire logic flag_read,
	input wire logic [FLAG_W-1:0] flag_rdata,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe
);
	logic quiet;
	assign quiet = !(proximity_valid | ambient_light_valid | protection_enter_event
		| protection_leave_event);
	// With persistence 1 a repeat above-sample belongs to the same excursion and fires nothing
	logic prox_was_above_r;
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
			prox_was_above_r <= 1'b0;
		else if (proximity_valid)
			prox_was_above_r <= proximity_data > proximity_high_threshold;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_od_low: assert property (irq_pin_out == 1'b0)
		else $error("pin value not zero");
	a_rsvd_zero: assert property (flag_rdata[3:2] == 2'b00)
		else $error("reserved bits set");
	a_prox_close: assert property (proximity_valid && proximity_irq_select
		&& !prox_was_above_r && proximity_data > proximity_high_threshold
		&& proximity_persistence == 2'h0 |=> irq_pin_oe)
		else $error("close sample gave no interrupt");
	a_oe_hold: assert property (irq_pin_oe && !flag_read |=> irq_pin_oe)
		else $error("pin released without read");
	a_read_release: assert property (flag_read && quiet |=> !irq_pin_oe)
		else $error("pin kept low after read");
	a_no_cause: assert property (!irq_pin_oe && quiet |=> !irq_pin_oe)
		else $error("pin fell with no event");
	a_read_shows: assert property (flag_read && irq_pin_oe |=> flag_rdata != 8'h00)
		else $error("read lost pending flags");
	a_idle_read: assert property (flag_read && !irq_pin_oe |=> flag_rdata == 8'h00)
		else $error("idle read not zero");
endmodule
bind sensor_threshold_interrupt irq_chk chk_i (.*);

//--- bench/host_model.sv
`timescale 1ns/1ps
module host_model
(
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe,
	input wire logic rd_cmd,
	output logic flag_read,
	output wire int_n
);
	assign int_n = irq_pin_oe ? irq_pin_out : 1'b1; // Pull-up wins when released
	assign flag_read = rd_cmd; // Acknowledge by reading, normally after a fall
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk_sys = 0, resetn = 0, flag_read, rc = 0, irq_pin_out, irq_pin_oe;
	logic [1:0] en = 2'b11;
	logic [3:0] pers = 4'h0, ev = 4'h0;
	logic [15:0] dat = 16'h0000;
	logic [7:0] flag_rdata;
	wire int_n;
	int failures = 0, checks_done = 0;
	always #5 clk_sys = ~clk_sys;
	sensor_threshold_interrupt uut (.*, .ambient_irq_enable(en[0]), .proximity_irq_select(en[1]),
		.ambient_persistence(pers[1:0]), .proximity_persistence(pers[3:2]),
		.ambient_light_valid(ev[0]), .proximity_valid(ev[1]), .protection_enter_event(ev[2]),
		.protection_leave_event(ev[3]), .ambient_light_data(dat), .proximity_data(dat[7:0]),
		.ambient_high_threshold(16'h1000), .ambient_low_threshold(16'h0100),
		.proximity_high_threshold(8'h80), .proximity_low_threshold(8'h20));
	host_model host (.irq_pin_out, .irq_pin_oe, .rd_cmd(rc), .flag_read, .int_n);
	task report_and_stop;
		$display("failures %0d checks %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task pin(input logic e);
		chk("int_n", {7'h00, e}, {7'h00, int_n});
	endtask
	// One idle cycle follows each sample so pulses never merge
	task pulse(input int k, input logic [15:0] d);
		@(posedge clk_sys);
		ev <= 4'h1 << k;
		dat <= d;
		@(posedge clk_sys);
		ev <= 4'h0;
		#1;
	endtask
	task rd(input logic [7:0] e);
		@(posedge clk_sys);
		rc <= 1'b1;
		@(posedge clk_sys);
		rc <= 1'b0;
		#1;
		chk("flags", e, flag_rdata);
		pin(1'b1);
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'h00);
		pulse(1, 16'h0080);
		pin(1'b1);
		pulse(1, 16'h0081);
		pin(1'b0);
		rd(8'h02);
		pulse(1, 16'h0050);
		pin(1'b1);
		pulse(1, 16'h001F);
		rd(8'h01);
		for (int k = 0; k < 4; k++)
			pulse(k < 2 ? 0 : k, k[0] ? 16'h00FF : 16'h1001);
		rd(8'hF0);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys) pers <= {i[1:0], i[1:0]};
			repeat ((1 << i) - 1) pulse(0, 16'h2000);
			pin(1'b1);
			pulse(0, 16'h2000);
			rd(8'h10);
			pulse(0, 16'h0800);
			repeat (i) pulse(1, 16'h0090);
			pin(1'b1);
			pulse(1, 16'h0090);
			rd(8'h02);
			pulse(1, 16'h0050);
		end
		@(posedge clk_sys)
		begin
			en <= 2'b00;
			pers <= 4'h0;
		end
		for (int k = 0; k < 4; k++)
			pulse(k, 16'h2000);
		pin(1'b1);
		rd(8'h00);
		@(posedge clk_sys) en <= 2'b11;
		pulse(2, 16'h0000);
		rd(8'h40);
		pulse(3, 16'h0000);
		pin(1'b0);
		@(posedge clk_sys) resetn <= 1'b0;
		@(posedge clk_sys) resetn <= 1'b1;
		#1;
		chk("flags", 8'h00, flag_rdata);
		pin(1'b1);
		rd(8'h00);
		report_and_stop;
	end
	initial
	begin
		#200000;
		failures++;
		report_and_stop;
	end
endmodule
